// >>> rtl/fpec_ctrl.sv
// Flash program and erase controller: lock sequencing, sector guard,
// frequency-scaled pulse timing, CPU stall.
// Assumes register writes and flash writes are one-cycle strobes.
// Functional notes
// - Reset leaves the controller locked.
// - Out-of-sequence command or page write relocks.
// - Unlock: 00, page, 73, 8C, same page.
// - Frequency bytes form kHz value for timing.
// - Command 5E selects guard at page address.
// - Guard writes only set bits.
// - Any other command deselects the guard.
// - Guard clears to zero on reset.
// - Guard lives at FF9; 00 returns reset.
// - Write protect option blocks program and erase.
// - Read protect blocks debug and bypass reads.
// - Program only inside the unlocked page.
// - Programming only clears bits; erase sets FF.
// - CPU stalls while a byte programs.
// - Command 00 ends programming and locks.
// - Protected sectors are never programmed or erased.
// - Command 95 after unlock erases the page.
// - Erase fills page with FF, stalling CPU.
// - Erase completion relocks the controller.
// - Mass erase from user code is rejected.
// - Status codes report lock and busy state.
// - Page field drives address bits 15 to 9.
module fpec_ctrl
   import fpec_pkg::*;
#(
   parameter int PROG_US  = FPEC_PROG_US,
   parameter int ERASE_US = FPEC_ERASE_US
)(
   input  wire logic          CLK_SYS,
   input  wire logic          RST_N,
   input  wire logic          REG_WR,
   input  wire logic [11:0]   REG_ADDR,
   input  wire logic [7:0]    REG_WDATA,
   output logic [7:0]         REG_RDATA,
   input  wire fpec_mem_req_t MEM_REQ,
   input  wire logic          OPT_WRITE_PROT,
   input  wire logic          OPT_READ_PROT,
   output logic               CPU_STALL,
   output logic               FLASH_PROG,
   output logic               FLASH_ERASE,
   output logic [15:0]        FLASH_ADDR,
   output logic [7:0]         FLASH_WDATA,
   output logic               EXT_READ_BLOCK
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   fpec_state_t state_reg;        // Sequencer state.
   fpec_state_t state_next;       // Its next value.
   logic        guard_sel_reg;    // Sector guard selected at FF9.
   logic [7:0]  guard_reg;        // Sector guard, one bit per sector.
   logic [7:0]  page_reg;         // Info enable and page number.
   logic [15:0] freq_reg;         // Clock frequency in kHz.
   logic [31:0] cnt_reg;          // Pulse cycle counter.
   logic        erasing_reg;      // Busy with an erase, not a program.

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire cmd_wr  = REG_WR && (REG_ADDR == FPEC_ADDR_CMD);
   wire page_wr = REG_WR && (REG_ADDR == FPEC_ADDR_PAGE);
   wire busy    = (state_reg == FPEC_S_BUSY);

   // Sector of a page: top three bits of the 7-bit page number.
   function automatic logic sect_guarded(input logic [6:0] pg,
                                         input logic [7:0] g);
      sect_guarded = g[pg[6:4]];
   endfunction

   // Cycles for a pulse: kHz times microseconds over 1000, at least 1.
   function automatic logic [31:0] pulse_cycles(input logic [15:0] khz,
                                                input int us);
      logic [31:0] c;
      c = 32'((32'(khz) * 32'(us)) / 32'(FPEC_US_PER_MS));
      pulse_cycles = (c == 32'h0) ? 32'h1 : c;
   endfunction

   wire page_guarded = sect_guarded(page_reg[6:0], guard_reg);
   // Operations are allowed only when neither option nor guard forbids.
   wire op_ok = !OPT_WRITE_PROT && !page_guarded;
   wire in_page = (MEM_REQ.addr[15:9] == page_reg[6:0]);
   // A command or page write in the same cycle wins, so a 00 in the open state always relocks.
   wire prog_go = (state_reg == FPEC_S_OPEN) && MEM_REQ.wr
                  && in_page && op_ok && !cmd_wr && !page_wr;
   wire erase_go = (state_reg == FPEC_S_OPEN) && cmd_wr
                   && (REG_WDATA == FPEC_CMD_PERASE) && op_ok;
   wire done = busy && (cnt_reg == 32'h1);

   // ---------------------------------------------------------------
   // Next state. Command, page and program writes while busy are ignored; the CPU is stalled.
   // ---------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         FPEC_S_LOCKED:
         begin
            // Unlock path starts with a page write while the guard is deselected.
            if (page_wr && !guard_sel_reg)
               state_next = FPEC_S_PAGE1;
         end
         FPEC_S_PAGE1:
         begin
            if (cmd_wr)
               state_next = (REG_WDATA == FPEC_CMD_UNLK1) ?
                            FPEC_S_FIRST : FPEC_S_LOCKED;
            else if (page_wr)
               state_next = FPEC_S_LOCKED;
         end
         FPEC_S_FIRST:
         begin
            if (cmd_wr)
               state_next = (REG_WDATA == FPEC_CMD_UNLK2) ?
                            FPEC_S_SECOND : FPEC_S_LOCKED;
            else if (page_wr)
               state_next = FPEC_S_LOCKED;
         end
         FPEC_S_SECOND:
         begin
            // Same page rewritten opens it; a different page relocks.
            if (page_wr)
               state_next = (REG_WDATA == page_reg) ?
                            FPEC_S_OPEN : FPEC_S_LOCKED;
            else if (cmd_wr)
               state_next = FPEC_S_LOCKED;
         end
         FPEC_S_OPEN:
         begin
            if (erase_go || prog_go)
               state_next = FPEC_S_BUSY;
            else if (cmd_wr || page_wr)
               state_next = FPEC_S_LOCKED;
         end
         FPEC_S_BUSY:
         begin
            // Erase relocks; a program returns to the open page.
            if (done)
               state_next = erasing_reg ?
                            FPEC_S_LOCKED : FPEC_S_OPEN;
         end
         default: state_next = FPEC_S_LOCKED;
      endcase
   end

   // ---------------------------------------------------------------
   // State register.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         state_reg <= FPEC_S_LOCKED;
      else
         state_reg <= state_next;
   end

   // ---------------------------------------------------------------
   // Guard select: set by 5E, cleared by any other command.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         guard_sel_reg <= 1'b0;
      else if (cmd_wr && !busy)
         guard_sel_reg <= (REG_WDATA == FPEC_CMD_GUARD);
   end

   // ---------------------------------------------------------------
   // Sector guard: set-only, lost on reset.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         guard_reg <= FPEC_GUARD_RST;
      else if (page_wr && guard_sel_reg && !busy)
         guard_reg <= guard_reg | REG_WDATA;
   end

   // ---------------------------------------------------------------
   // Page select: frozen once the page is open, so the unlocked page
   // cannot move underneath a program.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         page_reg <= FPEC_PAGE_RST;
      else if (page_wr && !guard_sel_reg
               && (state_reg == FPEC_S_LOCKED))
         page_reg <= REG_WDATA;
   end

   // ---------------------------------------------------------------
   // Frequency value in kHz, written one byte at a time.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         freq_reg <= FPEC_FREQ_RST;
      else if (REG_WR && REG_ADDR == FPEC_ADDR_FRQH)
         freq_reg[15:8] <= REG_WDATA;
      else if (REG_WR && REG_ADDR == FPEC_ADDR_FRQL)
         freq_reg[7:0] <= REG_WDATA;
   end

   // ---------------------------------------------------------------
   // Pulse counter, loaded at start, counts down to zero; the pulse ends at one.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cnt_reg     <= 32'h0;
         erasing_reg <= 1'b0;
      end
      else if (erase_go)
      begin
         cnt_reg     <= pulse_cycles(freq_reg, ERASE_US);
         erasing_reg <= 1'b1;
      end
      else if (prog_go)
      begin
         cnt_reg     <= pulse_cycles(freq_reg, PROG_US);
         erasing_reg <= 1'b0;
      end
      else if (busy && cnt_reg != 32'h0)
         cnt_reg <= cnt_reg - 32'h1;
   end

   // ---------------------------------------------------------------
   // Flash array strobes and CPU stall, all registered.
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         CPU_STALL   <= 1'b0;
         FLASH_PROG  <= 1'b0;
         FLASH_ERASE <= 1'b0;
         FLASH_ADDR  <= 16'h0000;
         FLASH_WDATA <= FPEC_ERASED;
      end
      else
      begin
         CPU_STALL   <= (state_next == FPEC_S_BUSY);
         FLASH_PROG  <= (state_next == FPEC_S_BUSY) &&
                        (prog_go || (busy && !erasing_reg));
         FLASH_ERASE <= (state_next == FPEC_S_BUSY) &&
                        (erase_go || (busy && erasing_reg));
         if (prog_go)
         begin
            FLASH_ADDR  <= {page_reg[6:0], MEM_REQ.addr[8:0]};
            FLASH_WDATA <= MEM_REQ.data;
         end
         else if (erase_go)
         begin
            FLASH_ADDR  <= {page_reg[6:0], 9'h000};
            FLASH_WDATA <= FPEC_ERASED;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read mux: status, page or guard, frequency bytes.
   // ---------------------------------------------------------------
   logic [5:0] stat;
   always_comb
   begin
      case (state_reg)
         FPEC_S_PAGE1:  stat = FPEC_ST_LOCKED;
         FPEC_S_FIRST:  stat = FPEC_ST_FIRST;
         FPEC_S_SECOND: stat = FPEC_ST_SECOND;
         FPEC_S_OPEN:   stat = FPEC_ST_UNLOCKED;
         FPEC_S_BUSY:   stat = erasing_reg ? FPEC_ST_ERASE : FPEC_ST_PROG;
         default:       stat = guard_sel_reg ? FPEC_ST_GUARD
                                             : FPEC_ST_LOCKED;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         REG_RDATA      <= 8'h00;
         EXT_READ_BLOCK <= 1'b0;
      end
      else
      begin
         EXT_READ_BLOCK <= OPT_READ_PROT;
         case (REG_ADDR)
            FPEC_ADDR_CMD:  REG_RDATA <= {2'b00, stat};
            FPEC_ADDR_PAGE: REG_RDATA <= guard_sel_reg ? guard_reg
                                                       : page_reg;
            FPEC_ADDR_FRQH: REG_RDATA <= freq_reg[15:8];
            FPEC_ADDR_FRQL: REG_RDATA <= freq_reg[7:0];
            default:        REG_RDATA <= 8'h00;
         endcase
      end
   end

endmodule // fpec_ctrl

// >>> rtl/fpec_pkg.sv
// Package for the flash program and erase controller.
// Assumes a single system clock and an 8-bit register file bus.
package fpec_pkg;

   // ---------------------------------------------------------------
   // Register file addresses
   // ---------------------------------------------------------------
   localparam logic [11:0] FPEC_ADDR_CMD   = 12'hFF8; // Command / status.
   localparam logic [11:0] FPEC_ADDR_PAGE  = 12'hFF9; // Page / sector guard.
   localparam logic [11:0] FPEC_ADDR_FRQH  = 12'hFFA; // Frequency high byte.
   localparam logic [11:0] FPEC_ADDR_FRQL  = 12'hFFB; // Frequency low byte.

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] FPEC_CMD_RESET   = 8'h00; // Reset and lock.
   localparam logic [7:0] FPEC_CMD_UNLK1   = 8'h73; // First unlock.
   localparam logic [7:0] FPEC_CMD_UNLK2   = 8'h8C; // Second unlock.
   localparam logic [7:0] FPEC_CMD_PERASE  = 8'h95; // Page erase.
   localparam logic [7:0] FPEC_CMD_MERASE  = 8'h63; // Mass erase, refused.
   localparam logic [7:0] FPEC_CMD_GUARD   = 8'h5E; // Select sector guard.

   // ---------------------------------------------------------------
   // Status codes and reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] FPEC_ST_LOCKED   = 6'h00;
   localparam logic [5:0] FPEC_ST_FIRST    = 6'h01;
   localparam logic [5:0] FPEC_ST_SECOND   = 6'h02;
   localparam logic [5:0] FPEC_ST_UNLOCKED = 6'h03;
   localparam logic [5:0] FPEC_ST_GUARD    = 6'h04;
   localparam logic [5:0] FPEC_ST_PROG     = 6'h08;
   localparam logic [5:0] FPEC_ST_ERASE    = 6'h10;
   localparam logic [7:0] FPEC_GUARD_RST   = 8'h00;
   localparam logic [7:0] FPEC_PAGE_RST    = 8'h00;
   localparam logic [15:0] FPEC_FREQ_RST   = 16'h0000;
   localparam logic [7:0] FPEC_ERASED      = 8'hFF;

   // ---------------------------------------------------------------
   // Pulse timing: microseconds of flash pulse per kHz-scaled tick
   // ---------------------------------------------------------------
   localparam int FPEC_PROG_US   = 40;    // Byte program pulse, in us.
   localparam int FPEC_ERASE_US  = 10000; // Page erase pulse, in us.
   localparam int FPEC_US_PER_MS = 1000;  // Scales kHz to cycles per us.

   // Controller states, one-hot.
   typedef enum logic [5:0] {
      FPEC_S_LOCKED = 6'b000001,
      FPEC_S_PAGE1  = 6'b000010,
      FPEC_S_FIRST  = 6'b000100,
      FPEC_S_SECOND = 6'b001000,
      FPEC_S_OPEN   = 6'b010000,
      FPEC_S_BUSY   = 6'b100000
   } fpec_state_t;

   // Request from the CPU to the flash array.
   typedef struct packed {
      logic        wr;    // Write strobe.
      logic [15:0] addr;  // Byte address.
      logic [7:0]  data;  // Byte to program.
   } fpec_mem_req_t;

endpackage : fpec_pkg

// >>> tb/fpec_ctrl_assertions.sv
// Checker for the flash controller, watching its top-level ports only.
// Assumes one clock domain and an asynchronous active-low reset.
module fpec_ctrl_chk
   import fpec_pkg::*;
#(
   parameter int PROG_US  = FPEC_PROG_US,
   parameter int ERASE_US = FPEC_ERASE_US
)(
   input wire logic          CLK_SYS,
   input wire logic          RST_N,
   input wire logic          REG_WR,
   input wire logic [11:0]   REG_ADDR,
   input wire logic [7:0]    REG_WDATA,
   input wire logic [7:0]    REG_RDATA,
   input wire fpec_mem_req_t MEM_REQ,
   input wire logic          OPT_WRITE_PROT,
   input wire logic          OPT_READ_PROT,
   input wire logic          CPU_STALL,
   input wire logic          FLASH_PROG,
   input wire logic          FLASH_ERASE,
   input wire logic [15:0]   FLASH_ADDR,
   input wire logic [7:0]    FLASH_WDATA,
   input wire logic          EXT_READ_BLOCK
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // Command write that the controller takes; stalls make it ignore one.
   wire cmd_wr = REG_WR && (REG_ADDR == FPEC_ADDR_CMD) && !CPU_STALL;

   chk_stall_pulse: assert property (
      (FLASH_PROG || FLASH_ERASE) |-> CPU_STALL)
      else $error("cpu runs during a flash pulse");
   chk_prog_target: assert property (
      $rose(FLASH_PROG) |-> $past(MEM_REQ.wr)
      && FLASH_ADDR == $past(MEM_REQ.addr)
      && FLASH_WDATA == $past(MEM_REQ.data))
      else $error("program pulse without matching request");
   chk_erase_cmd: assert property ($rose(FLASH_ERASE) |->
      $past(cmd_wr && REG_WDATA == FPEC_CMD_PERASE))
      else $error("erase began without erase command");
   chk_erase_page: assert property (
      FLASH_ERASE |-> FLASH_ADDR[8:0] == 9'h000
      && FLASH_WDATA == FPEC_ERASED)
      else $error("erase target malformed");
   chk_wp_blocks: assert property (
      ($rose(FLASH_PROG) || $rose(FLASH_ERASE)) |-> !$past(OPT_WRITE_PROT))
      else $error("write protect ignored");
   chk_rp_follows: assert property ($stable(OPT_READ_PROT) ##1
      $stable(OPT_READ_PROT) |-> EXT_READ_BLOCK == OPT_READ_PROT)
      else $error("read block does not follow option");
   chk_no_mass: assert property (
      cmd_wr && REG_WDATA == FPEC_CMD_MERASE |=> !FLASH_ERASE [*4])
      else $error("mass erase accepted");
   chk_lock_stops: assert property (
      cmd_wr && REG_WDATA == FPEC_CMD_RESET |=> !FLASH_PROG [*3])
      else $error("programmed after lock");
   chk_stall_cause: assert property (
      $rose(CPU_STALL) |-> $past(MEM_REQ.wr)
      || $past(cmd_wr && REG_WDATA == FPEC_CMD_PERASE))
      else $error("stall without request");

   cover property ($rose(FLASH_PROG));
   cover property ($rose(FLASH_ERASE));
   cover property (cmd_wr && REG_WDATA == FPEC_CMD_GUARD);
endmodule // fpec_ctrl_chk

// >>> tb/fpec_flash_model.sv
// Behavioural flash array behind the controller's pulse outputs.
// Assumes pulses are level signals sampled on the system clock.
module fpec_flash_model
   import fpec_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        FLASH_PROG,
   input wire logic        FLASH_ERASE,
   input wire logic [15:0] FLASH_ADDR,
   input wire logic [7:0]  FLASH_WDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sparse store; absent bytes read as erased.
   logic [7:0] mem [logic [15:0]];

   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : FPEC_ERASED;
   endfunction

   // Programming only clears bits, so repeating it per cycle is harmless.
   always @(posedge CLK_SYS)
   begin
      if (FLASH_PROG)
         mem[FLASH_ADDR] = peek(FLASH_ADDR) & FLASH_WDATA;
      if (FLASH_ERASE)
         for (logic [9:0] i = 10'h000; i < 10'h200; i++)
            mem.delete({FLASH_ADDR[15:9], i[8:0]});
   end
endmodule // fpec_flash_model

// >>> tb/tb.sv
// Self-checking bench for the flash controller with a flash model.
// Assumes a 100 MHz clock and a frequency value of 100, in kHz units.
module tb
   import fpec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ERASE_US = 100;
   localparam int N_PROG   = 100 * FPEC_PROG_US / 1000;
   localparam int N_ERASE  = 100 * ERASE_US / 1000;
   logic          clk_sys = 1'b0;
   logic          rst_n = 1'b0;
   logic          reg_wr = 1'b0;
   logic [11:0]   reg_addr = 12'h000;
   logic [7:0]    reg_wdata = 8'h00;
   fpec_mem_req_t mem_req = '0;
   logic          opt_wp = 1'b0;
   logic          opt_rp = 1'b0;
   logic [7:0]    reg_rdata, flash_wdata;
   logic          cpu_stall, flash_prog, flash_erase, ext_read_block;
   logic [15:0]   flash_addr;
   logic [31:0]   lfsr = 32'hE61E98C5;
   int            miscompares = 0;
   int            samples_checked = 0;

   always #5 clk_sys = ~clk_sys;

   fpec_ctrl #(.PROG_US(FPEC_PROG_US), .ERASE_US(ERASE_US)) DUT (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_WR(reg_wr),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .MEM_REQ(mem_req), .OPT_WRITE_PROT(opt_wp), .OPT_READ_PROT(opt_rp),
      .CPU_STALL(cpu_stall), .FLASH_PROG(flash_prog),
      .FLASH_ERASE(flash_erase), .FLASH_ADDR(flash_addr),
      .FLASH_WDATA(flash_wdata), .EXT_READ_BLOCK(ext_read_block));
   fpec_flash_model flash (.CLK_SYS(clk_sys), .FLASH_PROG(flash_prog),
      .FLASH_ERASE(flash_erase), .FLASH_ADDR(flash_addr),
      .FLASH_WDATA(flash_wdata));

   task automatic end_sim;
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   // Random byte from a shift register with a fixed start value.
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data is registered, so wait two edges after the address.
   task automatic chkreg(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      repeat (2) @(posedge clk_sys);
      #1;
      check({8'h00, reg_rdata}, {8'h00, e});
   endtask
   // Counts stall cycles over a window longer than any pulse used here.
   task automatic stalls(input int e);
      int n;
      n = 0;
      repeat (30)
      begin
         if (cpu_stall === 1'b1) n++;
         @(posedge clk_sys);
         #1;
      end
      check(16'(n), 16'(e));
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      mem_req <= {1'b1, a, d};
      @(posedge clk_sys);
      mem_req.wr <= 1'b0;
      #1;
   endtask
   task automatic unlock(input logic [7:0] p);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_RESET);
      wreg(FPEC_ADDR_PAGE, p);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_UNLK1);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_UNLK2);
      wreg(FPEC_ADDR_PAGE, p);
   endtask

   initial
   begin
      #200000;
      miscompares++;
      end_sim();
   end

   initial
   begin
      logic [7:0]  p, o, d1, d2;
      logic [15:0] a;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      chkreg(FPEC_ADDR_CMD, 8'h00);
      wreg(FPEC_ADDR_FRQH, 8'h00);
      wreg(FPEC_ADDR_FRQL, 8'h64);
      prog(16'h2000, 8'h00);
      stalls(0);
      p = rnd();
      o = rnd();
      d1 = rnd();
      d2 = rnd();
      p = (p & 8'h7F) | 8'h10;
      a = {p[6:0], 1'b0, o};
      unlock(p);
      chkreg(FPEC_ADDR_CMD, {2'b00, FPEC_ST_UNLOCKED});
      prog(a, d1);
      stalls(N_PROG);
      prog(a, d2);
      stalls(N_PROG);
      check({8'h00, flash.peek(a)}, {8'h00, d1 & d2});
      prog({p[6:0] + 7'h01, 9'h000}, 8'h00);
      stalls(0);
      check({8'h00, flash.peek({p[6:0] + 7'h01, 9'h000})}, 16'h00FF);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_RESET);
      chkreg(FPEC_ADDR_CMD, 8'h00);
      wreg(FPEC_ADDR_PAGE, p);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_UNLK1);
      chkreg(FPEC_ADDR_CMD, {2'b00, FPEC_ST_FIRST});
      wreg(FPEC_ADDR_CMD, FPEC_CMD_UNLK1);
      chkreg(FPEC_ADDR_CMD, 8'h00);
      unlock(p);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_MERASE);
      stalls(0);
      check({8'h00, flash.peek(a)}, {8'h00, d1 & d2});
      unlock(p);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_PERASE);
      stalls(N_ERASE);
      check({8'h00, flash.peek(a)}, 16'h00FF);
      chkreg(FPEC_ADDR_CMD, 8'h00);
      @(posedge clk_sys);
      opt_wp <= 1'b1;
      opt_rp <= 1'b1;
      unlock(p);
      prog(a, 8'h00);
      stalls(0);
      check({15'h0000, ext_read_block}, 16'h0001);
      @(posedge clk_sys);
      opt_wp <= 1'b0;
      opt_rp <= 1'b0;
      wreg(FPEC_ADDR_CMD, FPEC_CMD_RESET);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_GUARD);
      chkreg(FPEC_ADDR_CMD, {2'b00, FPEC_ST_GUARD});
      wreg(FPEC_ADDR_PAGE, 8'h01);
      wreg(FPEC_ADDR_PAGE, 8'h00);
      chkreg(FPEC_ADDR_PAGE, 8'h01);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_RESET);
      wreg(FPEC_ADDR_PAGE, 8'h25);
      chkreg(FPEC_ADDR_PAGE, 8'h25);
      unlock(8'h05);
      prog(16'h0A00, 8'h00);
      stalls(0);
      wreg(FPEC_ADDR_CMD, FPEC_CMD_PERASE);
      stalls(0);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      wreg(FPEC_ADDR_CMD, FPEC_CMD_GUARD);
      chkreg(FPEC_ADDR_PAGE, 8'h00);
      end_sim();
   end
endmodule // tb

bind fpec_ctrl fpec_ctrl_chk #(.PROG_US(PROG_US), .ERASE_US(ERASE_US)) u_chk (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ),
   .OPT_WRITE_PROT(OPT_WRITE_PROT), .OPT_READ_PROT(OPT_READ_PROT),
   .CPU_STALL(CPU_STALL), .FLASH_PROG(FLASH_PROG), .FLASH_ERASE(FLASH_ERASE),
   .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA),
   .EXT_READ_BLOCK(EXT_READ_BLOCK));
